// ---- common/host_port_pkg.sv ----
// Package: address map, field layout and sizes of the timing buffer host port
`default_nettype none
package host_port_pkg;
  // Region offsets relative to the window base
  localparam logic [13:0] RX_BUF_OFFSET = 14'h0000;
  localparam logic [13:0] RX_BUF_LAST = 14'h0FFF;
  localparam logic [13:0] TX_BUF_OFFSET = 14'h1000;
  localparam logic [13:0] TX_BUF_LAST = 14'h17FF;
  localparam logic [13:0] TX_CTRL_OFFSET = 14'h2000;
  localparam logic [13:0] RX_CTRL_OFFSET = 14'h2004;
  localparam int OFFSET_W = 14;
  // Buffer sizes
  localparam int RX_BUF_BYTES = 4096;
  localparam int TX_BUF_BYTES = 2048;
  localparam int TX_REGIONS = 8;
  localparam int TX_REGION_BYTES = 256;
  localparam int RX_SLOTS = 16;
  // Transmit control fields
  localparam int TX_SEND_LSB = 0;
  localparam int TX_WAIT_LSB = 8;
  localparam int TX_LAST_LSB = 16;
  // Receive control fields
  localparam int RX_FLUSH_BIT = 0;
  localparam int RX_LAST_LSB = 8;
  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Bus slave sequence
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} bus_state_t;
endpackage : host_port_pkg
`default_nettype wire

// ---- common/tx_sched_if.sv ----
// Interface: pending-request set and grant between bus slave and scheduler
`default_nettype none
interface tx_sched_if #(parameter int REGIONS = 8);
  logic [REGIONS-1:0] pending;
  logic [REGIONS-1:0] grant_onehot;
  logic grant_valid;
  modport sched (input pending, output grant_onehot, output grant_valid);
  modport owner (output pending, input grant_onehot, input grant_valid);
endinterface : tx_sched_if
`default_nettype wire

// ---- design/tx_priority_pick.sv ----
// Lowest-numbered pending region picker
`default_nettype none
module tx_priority_pick #(
  parameter int REGIONS = 8
) (
  tx_sched_if.sched sel
);
  // Scan from the top down so the lowest pending bit wins
  always_comb begin
    sel.grant_onehot = '0;
    sel.grant_valid = 1'b0;
    for (int i = REGIONS - 1; i >= 0; i--) begin
      if (sel.pending[i]) begin
        sel.grant_onehot = '0;
        sel.grant_onehot[i] = 1'b1;
        sel.grant_valid = 1'b1;
      end
    end
  end
endmodule : tx_priority_pick
`default_nettype wire

// ---- design/ptp_buffer_host_port.sv ----
// Host bus slave for the timing packet buffers and their control registers
`default_nettype none
// Behaviour
// - 32-bit data, single transfers only
// - Address phase stretched with wait, late addrAck
// - Read data acknowledge may be delayed
// - Write data acknowledge may be delayed
// - Byte addresses relative to configurable base
// - Receive buffer 4k bytes, read-only
// - Transmit buffer 0x1000-0x17FF read/write
// - Send-request bits 7-0, write-one, read zero
// - Eight 256-byte regions, granted frame transmitted
// - Bits 15-8 pending until frame sent
// - Bits 18-16 last transmitted region
// - Transmit register access clears transmit interrupt
// - Flush bit empties receive buffer, reads zero
// - Bits 11-8 last received slot
// - Receive register access clears receive interrupt
// - Lowest-numbered pending region served first
// - Receive slots ascend from 0, wrap after 15
module ptp_buffer_host_port #(
  parameter logic [31:0] WINDOW_BASE = 32'h0000_0000,
  parameter int TX_REGIONS = host_port_pkg::TX_REGIONS,
  parameter int RX_SLOTS = host_port_pkg::RX_SLOTS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Processor bus request
  input wire logic pavalid_i,
  input wire logic rnw_i,
  input wire logic [31:0] abus_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wrdbus_i,
  // Processor bus answer
  output logic sl_addrack_o,
  output logic sl_wait_o,
  output logic sl_rddack_o,
  output logic [31:0] sl_rddbus_o,
  output logic sl_wrdack_o,
  // Transmit side (arbiter)
  output logic tx_req_valid_o,
  output logic [2:0] tx_req_region_o,
  input wire logic tx_req_ack_i,
  input wire logic tx_done_i,
  input wire logic [10:0] tx_rd_addr_i,
  output logic [7:0] tx_rd_data_o,
  input wire logic tx_ts_we_i,
  input wire logic [10:0] tx_ts_addr_i,
  input wire logic [7:0] tx_ts_data_i,
  // Receive side (splitter)
  input wire logic rx_we_i,
  input wire logic [7:0] rx_wr_offset_i,
  input wire logic [7:0] rx_wr_data_i,
  input wire logic rx_done_i,
  output logic [3:0] rx_wr_slot_o,
  output logic rx_flush_o,
  // Completion interrupts
  output logic tx_irq_o,
  output logic rx_irq_o
);
  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  logic [7:0] rx_mem [host_port_pkg::RX_BUF_BYTES];
  logic [7:0] tx_mem [host_port_pkg::TX_BUF_BYTES];
  host_port_pkg::bus_state_t state_ff, nxt_state;
  logic [31:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] be_ff;
  logic [31:0] rdata_ff;
  logic [TX_REGIONS-1:0] waiting_ff;
  logic [2:0] last_tx_ff;
  logic [2:0] active_region_ff;
  logic busy_ff;
  logic [3:0] wr_slot_ff;
  logic [3:0] last_rx_ff;
  logic tx_irq_ff, rx_irq_ff;
  logic flush_ff;

  tx_sched_if #(.REGIONS(TX_REGIONS)) sched ();
  tx_priority_pick #(.REGIONS(TX_REGIONS)) u_pick (.sel(sched.sched));

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [31:0] rel_addr;
  logic [host_port_pkg::OFFSET_W-1:0] off;
  logic in_window, hit_rx, hit_tx, hit_txc, hit_rxc;
  logic [31:0] req_rel;
  logic req_in_window;
  assign req_rel = abus_i - WINDOW_BASE;
  assign req_in_window = (abus_i >= WINDOW_BASE) &&
                         (req_rel[31:host_port_pkg::OFFSET_W] == '0);
  assign rel_addr = addr_ff - WINDOW_BASE;
  assign off = rel_addr[host_port_pkg::OFFSET_W-1:0];
  assign in_window = (addr_ff >= WINDOW_BASE) &&
                     (rel_addr[31:host_port_pkg::OFFSET_W] == '0);
  assign hit_rx = in_window && off <= host_port_pkg::RX_BUF_LAST;
  assign hit_tx = in_window && off >= host_port_pkg::TX_BUF_OFFSET &&
                  off <= host_port_pkg::TX_BUF_LAST;
  assign hit_txc = in_window &&
                   off[13:2] == host_port_pkg::TX_CTRL_OFFSET[13:2];
  assign hit_rxc = in_window &&
                   off[13:2] == host_port_pkg::RX_CTRL_OFFSET[13:2];

  // Word-aligned byte index into each buffer
  logic [11:0] rx_word;
  logic [10:0] tx_word;
  assign rx_word = {off[11:2], 2'b00};
  assign tx_word = {off[10:2], 2'b00};

  // ----------------------------------------------------------------
  // Bus slave sequence
  // ----------------------------------------------------------------
  // One transfer at a time: the address is acked only from idle,
  // so a second request simply waits in the address phase
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      host_port_pkg::ST_IDLE: begin
        if (pavalid_i && req_in_window) begin
          nxt_state = rnw_i ? host_port_pkg::ST_READ : host_port_pkg::ST_WRITE;
        end
      end
      host_port_pkg::ST_READ: nxt_state = host_port_pkg::ST_IDLE;
      host_port_pkg::ST_WRITE: nxt_state = host_port_pkg::ST_IDLE;
      default: nxt_state = host_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= host_port_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Address ack only when idle; wait held while busy
  assign sl_addrack_o = (state_ff == host_port_pkg::ST_IDLE) && pavalid_i && req_in_window;
  assign sl_wait_o = (state_ff != host_port_pkg::ST_IDLE) && pavalid_i && req_in_window;

  // Latch the single transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_ff <= 32'h0000_0000;
      wdata_ff <= 32'h0000_0000;
      be_ff <= 4'h0;
    end else if (sl_addrack_o) begin
      addr_ff <= abus_i;
      wdata_ff <= wrdbus_i;
      be_ff <= be_i;
    end
  end

  // Write data acknowledge comes one cycle after the address, read data acknowledge two cycles after
  logic rd_phase, wr_phase;
  assign rd_phase = state_ff == host_port_pkg::ST_READ;
  assign wr_phase = state_ff == host_port_pkg::ST_WRITE;
  assign sl_wrdack_o = wr_phase;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sl_rddack_o <= 1'b0;
    end else begin
      sl_rddack_o <= rd_phase;
    end
  end
  assign sl_rddbus_o = rdata_ff;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Control words expose only documented fields; the rest reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= host_port_pkg::CTRL_RESET;
    end else if (rd_phase) begin
      rdata_ff <= host_port_pkg::CTRL_RESET;
      if (hit_rx) begin
        for (int b = 0; b < 4; b++) begin
          rdata_ff[8*b +: 8] <= rx_mem[rx_word + 12'(b)];
        end
      end else if (hit_tx) begin
        for (int b = 0; b < 4; b++) begin
          rdata_ff[8*b +: 8] <= tx_mem[tx_word + 11'(b)];
        end
      end else if (hit_txc) begin
        // Send bits read zero
        rdata_ff[host_port_pkg::TX_WAIT_LSB +: TX_REGIONS] <= waiting_ff;
        rdata_ff[host_port_pkg::TX_LAST_LSB +: 3] <= last_tx_ff;
      end else if (hit_rxc) begin
        rdata_ff[host_port_pkg::RX_LAST_LSB +: 4] <= last_rx_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer memories
  // ----------------------------------------------------------------
  // Host writes to receive space are dropped
  always_ff @(posedge clk_i) begin
    if (rx_we_i) begin
      rx_mem[{wr_slot_ff, rx_wr_offset_i}] <= rx_wr_data_i;
    end
  end

  // Host byte-lane writes take priority over timestamp writeback
  always_ff @(posedge clk_i) begin
    if (wr_phase && hit_tx) begin
      for (int b = 0; b < 4; b++) begin
        if (be_ff[b]) begin
          tx_mem[tx_word + 11'(b)] <= wdata_ff[8*b +: 8];
        end
      end
    end else if (tx_ts_we_i) begin
      tx_mem[tx_ts_addr_i] <= tx_ts_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    tx_rd_data_o <= tx_mem[tx_rd_addr_i];
  end

  // ----------------------------------------------------------------
  // Transmit requests
  // ----------------------------------------------------------------
  logic txc_write, txc_access, rxc_access;
  assign txc_write = wr_phase && hit_txc && be_ff[0];
  assign txc_access = (wr_phase || rd_phase) && hit_txc;
  assign rxc_access = (wr_phase || rd_phase) && hit_rxc;

  // Pending until sent; a new request beats the same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waiting_ff <= '0;
    end else begin
      waiting_ff <= (waiting_ff & ~(busy_ff && tx_done_i ?
                      (TX_REGIONS'(1) << active_region_ff) : '0)) |
                    (txc_write ? wdata_ff[host_port_pkg::TX_SEND_LSB +: TX_REGIONS]
                               : '0);
    end
  end

  // Requests not yet granted go to the picker, only while no frame is in flight
  logic [TX_REGIONS-1:0] queued;
  assign queued = busy_ff ? (waiting_ff & ~(TX_REGIONS'(1) << active_region_ff))
                          : waiting_ff;
  assign sched.pending = busy_ff ? '0 : queued;

  logic [2:0] pick_idx;
  always_comb begin
    pick_idx = 3'h0;
    for (int i = 0; i < TX_REGIONS; i++) begin
      if (sched.grant_onehot[i]) begin
        pick_idx = 3'(i);
      end
    end
  end

  assign tx_req_valid_o = sched.grant_valid;
  assign tx_req_region_o = pick_idx;

  // One frame in flight; granted region is sent, then recorded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      active_region_ff <= 3'h0;
      last_tx_ff <= 3'h0;
    end else if (!busy_ff && tx_req_valid_o && tx_req_ack_i) begin
      busy_ff <= 1'b1;
      active_region_ff <= pick_idx;
    end else if (busy_ff && tx_done_i) begin
      busy_ff <= 1'b0;
      last_tx_ff <= active_region_ff;
    end
  end

  // ----------------------------------------------------------------
  // Receive slot tracking
  // ----------------------------------------------------------------
  // Slot counter wraps naturally at sixteen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_slot_ff <= 4'h0;
      last_rx_ff <= 4'h0;
    end else if (rx_done_i) begin
      last_rx_ff <= wr_slot_ff;
      wr_slot_ff <= wr_slot_ff + 4'h1;
    end
  end
  assign rx_wr_slot_o = wr_slot_ff;

  // Flush pulse toward the receive pointer logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_ff <= 1'b0;
    end else begin
      flush_ff <= wr_phase && hit_rxc && be_ff[0] &&
                  wdata_ff[host_port_pkg::RX_FLUSH_BIT];
    end
  end
  assign rx_flush_o = flush_ff;

  // ----------------------------------------------------------------
  // Completion interrupts
  // ----------------------------------------------------------------
  // A completion in the clearing cycle keeps the line raised
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_irq_ff <= 1'b0;
      rx_irq_ff <= 1'b0;
    end else begin
      if (busy_ff && tx_done_i) begin
        tx_irq_ff <= 1'b1;
      end else if (txc_access) begin
        tx_irq_ff <= 1'b0;
      end
      if (rx_done_i) begin
        rx_irq_ff <= 1'b1;
      end else if (rxc_access) begin
        rx_irq_ff <= 1'b0;
      end
    end
  end
  assign tx_irq_o = tx_irq_ff;
  assign rx_irq_o = rx_irq_ff;

endmodule : ptp_buffer_host_port
`default_nettype wire

// ---- dv/host_port_checker_assertions.sv ----
// Checker: port-level timing rules of the timing buffer host port
`default_nettype none
module host_port_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus side
  input wire logic rnw_i,
  input wire logic sl_addrack_o,
  input wire logic sl_rddack_o,
  input wire logic sl_wrdack_o,
  // Far side
  input wire logic tx_req_valid_o,
  input wire logic tx_req_ack_i,
  input wire logic tx_done_i,
  input wire logic tx_irq_o,
  input wire logic rx_done_i,
  input wire logic [3:0] rx_wr_slot_o,
  input wire logic rx_irq_o,
  input wire logic rx_flush_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Write data is taken one cycle after the address
  wr_data_ack_a: assert property (sl_addrack_o && !rnw_i |=> sl_wrdack_o)
    else $error("write ack missing");
  // Read data two cycles after the address
  rd_data_ack_a: assert property (
    sl_addrack_o && rnw_i |=> !sl_rddack_o ##1 sl_rddack_o)
    else $error("read ack late or early");
  single_addr_a: assert property (sl_addrack_o |=> !sl_addrack_o)
    else $error("address taken twice in a row");
  tx_one_flight_a: assert property (
    tx_req_valid_o && tx_req_ack_i |=> !tx_req_valid_o)
    else $error("request offered while frame in flight");
  tx_irq_cause_a: assert property ($rose(tx_irq_o) |-> $past(tx_done_i))
    else $error("tx interrupt without completion");
  tx_irq_set_a: assert property (tx_done_i |=> tx_irq_o)
    else $error("tx interrupt not raised");
  rx_slot_step_a: assert property (
    rx_done_i |=> rx_wr_slot_o == $past(rx_wr_slot_o) + 4'h1)
    else $error("rx slot did not advance");
  rx_irq_set_a: assert property (rx_done_i |=> rx_irq_o)
    else $error("rx interrupt not raised");
  flush_pulse_a: assert property (rx_flush_o |=> !rx_flush_o)
    else $error("flush longer than one cycle");
  // Main scenarios reached
  cover property (sl_rddack_o);
  cover property (tx_done_i);
  cover property (rx_done_i);
endmodule : host_port_checker
bind ptp_buffer_host_port host_port_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .rnw_i(rnw_i), .sl_addrack_o(sl_addrack_o),
  .sl_rddack_o(sl_rddack_o), .sl_wrdack_o(sl_wrdack_o), .tx_req_valid_o(tx_req_valid_o),
  .tx_req_ack_i(tx_req_ack_i), .tx_done_i(tx_done_i), .tx_irq_o(tx_irq_o),
  .rx_done_i(rx_done_i), .rx_wr_slot_o(rx_wr_slot_o), .rx_irq_o(rx_irq_o),
  .rx_flush_o(rx_flush_o));
`default_nettype wire

// ---- dv/tx_arbiter_model.sv ----
// Model of the transmit arbiter facing the host port
`default_nettype none
module tx_arbiter_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request side
  input wire logic req_valid_i,
  input wire logic [2:0] req_region_i,
  input wire logic [3:0] delay_i,
  // Answer side
  output logic ack_o,
  output logic done_o,
  output logic [10:0] rd_addr_o,
  output logic [2:0] granted_o
);
  logic [3:0] cnt_ff;
  logic busy_ff;
  // Grant after a settable wait, then send a 16-cycle frame
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    done_o <= 1'b0;
    if (rst_i) begin
      cnt_ff <= 4'h0;
      busy_ff <= 1'b0;
      granted_o <= 3'h0;
      rd_addr_o <= 11'h000;
    end else if (!busy_ff && req_valid_i && !ack_o) begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == delay_i) begin
        ack_o <= 1'b1;
        busy_ff <= 1'b1;
        cnt_ff <= 4'h0;
        granted_o <= req_region_i;
        rd_addr_o <= {req_region_i, 8'h00};
      end
    end else if (busy_ff) begin
      // Walks the region so the buffer read port is exercised
      rd_addr_o <= rd_addr_o + 11'h001;
      cnt_ff <= cnt_ff + 4'h1;
      busy_ff <= (cnt_ff != 4'hF);
      done_o <= (cnt_ff == 4'hF);
    end
  end
endmodule : tx_arbiter_model
`default_nettype wire

// ---- dv/tb_ptp_buffer_host_port.sv ----
// Testbench for the timing buffer host port
`default_nettype none
module tb_ptp_buffer_host_port;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BASE = 32'h0004_0000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic pav = 1'b0;
  logic rnw = 1'b0;
  logic [31:0] abus = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'h0;
  logic [3:0] dly = 4'h6;
  logic rx_we = 1'b0;
  logic rx_done = 1'b0;
  logic [7:0] rx_off = 8'h00;
  logic [7:0] rx_dat = 8'h00;
  logic addrack, rdack, wrack, tx_v, tx_ack, tx_done, flush, tx_irq, rx_irq;
  logic [31:0] rdbus;
  logic addr_wait;
  logic [7:0] tx_rd;
  logic [2:0] tx_reg, granted;
  logic [10:0] tx_ra;
  logic [3:0] slot;
  int miscompares = 0;
  int total_checks = 0;
  int flushes = 0;
  // Clock and flush pulse counter
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (flush === 1'b1) flushes++;
  ptp_buffer_host_port #(.WINDOW_BASE(BASE)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .pavalid_i(pav), .rnw_i(rnw), .abus_i(abus), .be_i(be),
    .wrdbus_i(wdat), .sl_addrack_o(addrack), .sl_wait_o(addr_wait), .sl_rddack_o(rdack),
    .sl_rddbus_o(rdbus), .sl_wrdack_o(wrack), .tx_req_valid_o(tx_v),
    .tx_req_region_o(tx_reg), .tx_req_ack_i(tx_ack), .tx_done_i(tx_done),
    .tx_rd_addr_i(tx_ra), .tx_rd_data_o(tx_rd), .tx_ts_we_i(1'b0), .tx_ts_addr_i(11'h000),
    .tx_ts_data_i(8'h00), .rx_we_i(rx_we), .rx_wr_offset_i(rx_off), .rx_wr_data_i(rx_dat),
    .rx_done_i(rx_done), .rx_wr_slot_o(slot), .rx_flush_o(flush), .tx_irq_o(tx_irq),
    .rx_irq_o(rx_irq));
  tx_arbiter_model arb (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(tx_v), .req_region_i(tx_reg),
    .delay_i(dly), .ack_o(tx_ack), .done_o(tx_done), .rd_addr_o(tx_ra), .granted_o(granted));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One single transfer; request held until the ack edge
  task automatic xfer(input logic r, input logic [13:0] off, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {pav, rnw, be, wdat, abus} <= {1'b1, r, b, d, BASE + {18'h0, off}};
    @(negedge clk_i);
    while (addrack !== 1'b1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    pav <= 1'b0;
    // Look at the acks mid-cycle, never in the edge that launches them
    @(negedge clk_i);
    while ((r ? rdack : wrack) !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    q = rdbus;
    @(posedge clk_i);
    check(n < 40, 32'h1);
  endtask : xfer
  task automatic wr(input logic [13:0] off, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] q;
    xfer(1'b0, off, d, b, q);
  endtask : wr
  task automatic rdc(input logic [13:0] off, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b1, off, 32'h0, 4'hF, q);
    check(q, exp);
  endtask : rdc
  task automatic pulse_rx_done;
    @(posedge clk_i);
    rx_done <= 1'b1;
    @(posedge clk_i);
    rx_done <= 1'b0;
  endtask : pulse_rx_done
  // Bounded wait for the transmit interrupt
  task automatic wait_tx_irq;
    int n;
    n = 0;
    while (tx_irq !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check({31'h0, tx_irq}, 32'h1);
  endtask : wait_tx_irq
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(14'h2000, 32'h0);
    rdc(14'h2004, 32'h0);
    $display("test reset values done");
  endtask : t_reset
  // Byte lanes of the transmit area, its second word and its last word
  task automatic t_txbuf;
    wr(14'h1004, 32'hA1B2C3D4, 4'hF);
    wr(14'h1004, 32'h00EE0000, 4'h4);
    rdc(14'h1004, 32'hA1EEC3D4);
    wr(14'h17FC, 32'h5A6B7C8D, 4'hF);
    rdc(14'h17FC, 32'h5A6B7C8D);
    $display("test tx buffer done");
  endtask : t_txbuf
  // Request held through the busy cycle: wait shown, then taken again
  task automatic t_wait;
    @(posedge clk_i);
    {pav, rnw, be, wdat, abus} <= {1'b1, 1'b0, 4'hF, 32'h1122_33C5, BASE + 32'h1000};
    @(negedge clk_i);
    check({30'h0, addrack, addr_wait}, 32'h2);
    @(negedge clk_i);
    check({30'h0, addrack, addr_wait}, 32'h1);
    @(negedge clk_i);
    check({30'h0, addrack, wrack}, 32'h2);
    @(posedge clk_i);
    pav <= 1'b0;
    // Arbiter port idles at byte 0 of region 0 before any grant
    repeat (2) @(negedge clk_i);
    check({24'h0, tx_rd}, 32'h0000_00C5);
    rdc(14'h1000, 32'h1122_33C5);
    $display("test address wait done");
  endtask : t_wait
  // Splitter bytes readable, host writes ignored, slots wrap, flush pulses
  task automatic t_rx;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      {rx_we, rx_off, rx_dat} <= {1'b1, i[7:0], 8'h10 + i[7:0]};
    end
    @(posedge clk_i);
    rx_we <= 1'b0;
    wr(14'h0000, 32'hFFFFFFFF, 4'hF);
    rdc(14'h0000, 32'h13121110);
    for (int i = 0; i < 18; i++) pulse_rx_done();
    @(negedge clk_i);
    check({31'h0, rx_irq}, 32'h1);
    check({28'h0, slot}, 32'h2);
    rdc(14'h2004, 32'h0000_0100);
    check({31'h0, rx_irq}, 32'h0);
    wr(14'h2004, 32'hFFFF_FFFF, 4'hF);
    repeat (2) @(posedge clk_i);
    check(flushes, 32'h1);
    rdc(14'h2004, 32'h0000_0100);
    $display("test rx path done");
  endtask : t_rx
  // Two requests at once, slow then prompt arbiter
  task automatic t_tx;
    wr(14'h2000, 32'h0000_000A, 4'h1);
    rdc(14'h2000, 32'h0000_0A00);
    wait_tx_irq();
    check({29'h0, granted}, 32'h1);
    rdc(14'h2000, 32'h0001_0800);
    check({31'h0, tx_irq}, 32'h0);
    wait_tx_irq();
    wr(14'h2000, 32'hFFFF_FF00, 4'hF);
    rdc(14'h2000, 32'h0003_0000);
    @(posedge clk_i);
    dly <= 4'h0;
    wr(14'h2000, 32'h0000_0080, 4'h1);
    wait_tx_irq();
    check({29'h0, granted}, 32'h7);
    rdc(14'h2000, 32'h0007_0000);
    $display("test tx requests done");
  endtask : t_tx
  task automatic summarize;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_txbuf();
    t_wait();
    t_rx();
    t_tx();
    summarize();
  end
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end
endmodule : tb_ptp_buffer_host_port
`default_nettype wire
